/* File: free_running_timer_counter_bench.sv */
// Purpose: Self-checking bench of frt_counter.
// Assumes: 100 MHz clock, synchronous active-low reset.
// Notes: Rates are checked as count differences over whole periods.
module free_running_timer_counter_bench;
	import frt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_b, ext_edge_select, overflow_irq_enable, cpu_irq_mask, halt_mode;
	logic ext_clock_bonded, src_en, overflow_flag, timer_irq, ext_clock_pin;
	logic [1:0] clock_select_bits;
	frt_access_type access;
	logic [7:0] count_high_byte, count_low_byte, alt_count_high_byte, alt_count_low_byte;
	logic [15:0] count_value, s0;
	logic [15:0] snap_q[$];
	logic [7:0] rnd = 8'h60;
	int fail_count = 0, total_checks = 0, d;
	frt_counter uut(.clk, .rst_b, .access, .clock_select_bits, .ext_edge_select,
		.overflow_irq_enable, .cpu_irq_mask, .halt_mode, .ext_clock_pin, .ext_clock_bonded,
		.count_high_byte, .count_low_byte, .alt_count_high_byte, .alt_count_low_byte,
		.count_value, .overflow_flag, .timer_irq);
	frt_ext_src src(.clk, .en(src_en), .pin(ext_clock_pin));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [7:0] nx(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task end_sim;
		$display("checks=%0d mismatches=%0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] g, e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One strobe; the model queue keeps the count seen by that strobe.
	task sb(input logic [6:0] a);
		@(posedge clk);
		access <= frt_access_type'(a);
		#1 snap_q.push_back(count_value);
		@(posedge clk);
		access <= '0;
		#1;
	endtask
	task rate(input int n, e);
		s0 = count_value;
		cyc(n);
		chk(count_value - s0, 16'(e));
	endtask
	initial begin
		rst_b = 1'b0;
		access = '0;
		{clock_select_bits, ext_edge_select, halt_mode, src_en} = '0;
		{overflow_irq_enable, cpu_irq_mask, ext_clock_bonded} = 3'h7;
		repeat (2) @(posedge clk);
		#1 chk(count_value, 16'hfffc);
		@(posedge clk) rst_b <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk) clock_select_bits <= 2'(i);
			cyc(2);
			rate(16 << i, 8);
		end
		@(posedge clk) {clock_select_bits, src_en} <= 3'h7;
		for (int e = 0; e < 3; e++) begin
			@(posedge clk) {ext_clock_bonded, ext_edge_select} <= {e < 2, e[0]};
			cyc(16);
			rate(64, e < 2 ? 8 : 0);
		end
		@(posedge clk) {clock_select_bits, src_en, ext_clock_bonded} <= 4'h1;
		for (int i = 0; i < 4; i++) begin
			rnd = nx(rnd);
			@(posedge clk) clock_select_bits <= {1'b0, rnd[3]};
			sb(i[0] ? 7'h08 : 7'h40);
			cyc(1 + rnd[2:0]);
			sb(i[0] ? 7'h08 : 7'h40);
			chk(i[0] ? alt_count_high_byte : count_high_byte, snap_q[$][15:8]);
			sb(i[0] ? 7'h04 : 7'h20);
			chk(i[0] ? alt_count_low_byte : count_low_byte, snap_q[$-2][7:0]);
			sb(i[0] ? 7'h04 : 7'h20);
			chk(i[0] ? alt_count_low_byte : count_low_byte, snap_q[$][7:0]);
		end
		@(posedge clk) clock_select_bits <= 2'h0;
		sb(7'h10);
		chk(count_value, 16'hfffc);
		cyc(3);
		sb(7'h02);
		chk(count_value, 16'hfffc);
		d = 0;
		while (overflow_flag !== 1'b1 && d < 40) begin
			cyc(1);
			d++;
		end
		chk(16'(overflow_flag), 16'h1);
		if (d == 40) end_sim();
		cyc(2);
		chk(16'(timer_irq), 16'h0);
		@(posedge clk) cpu_irq_mask <= 1'b0;
		cyc(2);
		chk(16'(timer_irq), 16'h1);
		sb(7'h04);
		sb(7'h20);
		chk(16'(overflow_flag), 16'h1);
		sb(7'h01);
		sb(7'h04);
		chk(16'(overflow_flag), 16'h1);
		sb(7'h20);
		cyc(2);
		chk(16'({overflow_flag, timer_irq}), 16'h0);
		@(posedge clk) halt_mode <= 1'b1;
		cyc(4);
		rate(10, 0);
		@(posedge clk) halt_mode <= 1'b0;
		cyc(4);
		rate(16, 8);
		end_sim();
	end
endmodule

/* File: frt_counter.sv */
// Purpose: Free running 16-bit counter with buffered byte reads and overflow flag.
// Assumes: Access strobes are one-cycle pulses from the CPU side on clk.
// Notes: Read data appear the cycle after the read strobe.
`include "frt_defs.svh"
module frt_counter
	import frt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// CPU access
	input frt_access_type access,
	// Configuration
	input wire logic [1:0] clock_select_bits,
	input wire logic ext_edge_select,
	input wire logic overflow_irq_enable,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	// External clock pin
	input wire logic ext_clock_pin,
	input wire logic ext_clock_bonded,
	// Read data and status
	output logic [7:0] count_high_byte,
	output logic [7:0] count_low_byte,
	output logic [7:0] alt_count_high_byte,
	output logic [7:0] alt_count_low_byte,
	output logic [`FRT_CNT_W-1:0] count_value,
	output logic overflow_flag,
	output logic timer_irq
);
	////////////////////////////////////////////////////////////////////////////////
	logic [`FRT_CNT_W-1:0] cnt_q;
	logic [`FRT_CNT_W-1:0] cnt_d;
	logic [7:0] low_buf_q;
	frt_seq_type seq_q;
	frt_seq_type seq_d;
	logic ovf_q;
	logic ovf_d;
	logic armed_q;
	logic armed_d;
	logic irq_q;
	logic [7:0] hi_q;
	logic [7:0] lo_q;
	logic [7:0] ahi_q;
	logic [7:0] alo_q;
	logic halt_meta_q;
	logic halt_q;
	logic pre_tick;
	logic ext_tick;
	logic use_ext;
	logic tick;
	logic wrap;
	logic any_hi_rd;
	logic any_lo_rd;
	logic lo_force;
	logic main_lo_acc;
	logic [7:0] lo_view;

	////////////////////////////////////////////////////////////////////////////////
	// Halt is a level from the power controller, so it is synchronised.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			halt_meta_q <= 1'b0;
			halt_q <= 1'b0;
		end else begin
			halt_meta_q <= halt_mode;
			halt_q <= halt_meta_q;
		end
	end

	frt_prescaler u_pre (
		.clk(clk),
		.rst_b(rst_b),
		.run(!halt_q),
		.sel(clock_select_bits),
		.tick(pre_tick)
	);

	frt_edge_sync u_ext (
		.clk(clk),
		.rst_b(rst_b),
		.pin(ext_clock_pin),
		.bonded(ext_clock_bonded),
		.rise_sel(ext_edge_select),
		.edge_pulse(ext_tick)
	);

	// Wait state has no input here, so counting goes on through it.
	assign use_ext = (clock_select_bits == `FRT_CC_EXT);
	assign tick = !halt_q && (use_ext ? ext_tick : pre_tick);
	assign wrap = tick && (cnt_q == `FRT_CNT_MAX);
	assign lo_force = access.wr_low | access.alt_wr_low;

	////////////////////////////////////////////////////////////////////////////////
	// Counter.
	assign cnt_d = lo_force ? `FRT_CNT_RESET : (tick ? cnt_q + 16'h0001 : cnt_q);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q <= `FRT_CNT_RESET;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Buffered 16-bit read, shared by both views.
	assign any_hi_rd = access.rd_high | access.alt_rd_high;
	assign any_lo_rd = access.rd_low | access.alt_rd_low;
	always_comb begin
		seq_d = seq_q;
		unique case (seq_q)
			FRT_SEQ_IDLE: begin
				if (any_hi_rd) begin
					seq_d = FRT_SEQ_HELD;
				end
			end
			FRT_SEQ_HELD: begin
				if (any_lo_rd) begin
					seq_d = FRT_SEQ_IDLE;
				end
			end
			default: begin
				seq_d = FRT_SEQ_IDLE;
			end
		endcase
	end
	assign lo_view = (seq_q == FRT_SEQ_HELD) ? low_buf_q : cnt_q[7:0];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seq_q <= FRT_SEQ_IDLE;
			low_buf_q <= 8'h00;
		end else begin
			seq_q <= seq_d;
			if (any_hi_rd && seq_q == FRT_SEQ_IDLE) begin
				low_buf_q <= cnt_q[7:0];
			end
		end
	end

	// Both views take the same count; only the flag clearing differs.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hi_q <= 8'h00;
			lo_q <= 8'h00;
			ahi_q <= 8'h00;
			alo_q <= 8'h00;
		end else begin
			if (access.rd_high) begin
				hi_q <= cnt_q[15:8];
			end
			if (access.rd_low) begin
				lo_q <= lo_view;
			end
			if (access.alt_rd_high) begin
				ahi_q <= cnt_q[15:8];
			end
			if (access.alt_rd_low) begin
				alo_q <= lo_view;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Overflow flag with two-step clearing; a new wrap wins over the clear.
	assign main_lo_acc = access.rd_low | access.wr_low;
	assign armed_d = (access.rd_status && ovf_q) ? 1'b1 : ((main_lo_acc || !ovf_q) ? 1'b0 : armed_q);
	assign ovf_d = wrap ? 1'b1 : ((armed_q && main_lo_acc) ? 1'b0 : ovf_q);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ovf_q <= 1'b0;
			armed_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ovf_q <= ovf_d;
			armed_q <= armed_d;
			irq_q <= ovf_d && overflow_irq_enable && !cpu_irq_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign count_high_byte = hi_q;
	assign count_low_byte = lo_q;
	assign alt_count_high_byte = ahi_q;
	assign alt_count_low_byte = alo_q;
	assign count_value = cnt_q;
	assign overflow_flag = ovf_q;
	assign timer_irq = irq_q;
endmodule

/* File: frt_counter_chk.sv */
// Purpose: Port checks of frt_counter.
// Assumes: One clock domain.
// Notes: Bound to every frt_counter.
module frt_counter_chk
	import frt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Watched ports
	input frt_access_type access,
	input wire logic overflow_irq_enable,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	input wire logic [7:0] count_high_byte,
	input wire logic [7:0] alt_count_high_byte,
	input wire logic [15:0] count_value,
	input wire logic overflow_flag,
	input wire logic timer_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic main_low = access.rd_low | access.wr_low;
	wire logic alt_low = access.alt_rd_low | access.alt_wr_low;
	main_reload_a: assert property (access.wr_low |=> count_value == 16'hfffc)
		else $error("main write did not reload");
	alt_reload_a: assert property (access.alt_wr_low |=> count_value == 16'hfffc)
		else $error("alt write did not reload");
	high_capture_a: assert property (access.rd_high |=>
		count_high_byte == $past(count_value[15:8])) else $error("high byte wrong");
	alt_capture_a: assert property (access.alt_rd_high |=>
		alt_count_high_byte == $past(count_value[15:8])) else $error("alt high wrong");
	wrap_flag_a: assert property ($past(count_value) == 16'hffff &&
		count_value == 16'h0000 |-> ##[0:1] overflow_flag) else $error("no overflow flag");
	irq_gate_a: assert property (timer_irq == (overflow_flag &&
		$past(overflow_irq_enable && !cpu_irq_mask))) else $error("irq wrong");
	alt_keep_a: assert property (overflow_flag && alt_low && !main_low |=>
		overflow_flag) else $error("alt access cleared flag");
	clear_cause_a: assert property ($fell(overflow_flag) |-> $past(main_low))
		else $error("flag cleared without low access");
	halt_hold_a: assert property (halt_mode [*4] ##1 (halt_mode && !access.wr_low &&
		!access.alt_wr_low) |=> $stable(count_value)) else $error("count moved in halt");
	cover property ($rose(overflow_flag));
	cover property ($fell(overflow_flag));
	cover property ($rose(timer_irq));
endmodule
bind frt_counter frt_counter_chk chk(.clk, .rst_b, .access, .overflow_irq_enable,
	.cpu_irq_mask, .halt_mode, .count_high_byte, .alt_count_high_byte, .count_value,
	.overflow_flag, .timer_irq);

/* File: frt_defs.svh */
// Purpose: Constants of the free running timer counter core.
// Assumes: One CPU clock domain, synchronous active-low reset.
// Notes: Included by the package and by every design file of the timer.
`ifndef FRT_DEFS_SVH
`define FRT_DEFS_SVH
`define FRT_CNT_W 16
`define FRT_CNT_RESET 16'hfffc
`define FRT_CNT_MAX 16'hffff
`define FRT_PRE_W 3
`define FRT_CC_DIV2 2'h0
`define FRT_CC_DIV4 2'h1
`define FRT_CC_DIV8 2'h2
`define FRT_CC_EXT 2'h3
`define FRT_EDGE_FALL 1'h0
`define FRT_EDGE_RISE 1'h1
`endif

/* File: frt_edge_sync.sv */
// Purpose: Synchronise the external clock pin and flag the chosen edge.
// Assumes: Pin is asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`include "frt_defs.svh"
module frt_edge_sync
	import frt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Pin and selection
	input wire logic pin,
	input wire logic bonded,
	input wire logic rise_sel,
	// Result
	output logic edge_pulse
);
	logic meta_q;
	logic sync_q;
	logic prev_q;
	logic pin_seen;
	assign pin_seen = pin | ~bonded;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= pin_seen;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end
	// Rising when the new sample is high after low, falling the other way.
	assign edge_pulse = (rise_sel == `FRT_EDGE_RISE) ? (sync_q & ~prev_q) : (~sync_q & prev_q);
endmodule

/* File: frt_ext_src.sv */
// Purpose: Drive the external timer clock pin.
// Assumes: Runs from the bench clock.
// Notes: The pin stands still while disabled.
module frt_ext_src #(
	parameter int HALF = 4
) (
	input wire logic clk,
	input wire logic en,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	initial pin = 1'b0;
	// A half period of four leaves eight CPU edges between active edges.
	always @(posedge clk) begin
		if (en) begin
			n <= (n == HALF - 1) ? 0 : n + 1;
			if (n == HALF - 1) pin <= ~pin;
		end
	end
endmodule

/* File: frt_pkg.sv */
// Purpose: Types shared by the free running timer counter files.
// Assumes: frt_defs.svh supplies the widths.
// Notes: Byte access strobes travel together as one struct.
`include "frt_defs.svh"
package frt_pkg;
	typedef struct packed {
		logic rd_high;
		logic rd_low;
		logic wr_low;
		logic alt_rd_high;
		logic alt_rd_low;
		logic alt_wr_low;
		logic rd_status;
	} frt_access_type;
	typedef enum logic [1:0] {
		FRT_SEQ_IDLE = 2'b01,
		FRT_SEQ_HELD = 2'b10
	} frt_seq_type;
endpackage

/* File: frt_prescaler.sv */
// Purpose: Divide the CPU clock by 2, 4 or 8 into a one-cycle tick.
// Assumes: Runs on clk only.
// Notes: Stopped while halted so counting resumes in phase.
`include "frt_defs.svh"
module frt_prescaler
	import frt_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control
	input wire logic run,
	input wire logic [1:0] sel,
	// Result
	output logic tick
);
	logic [`FRT_PRE_W-1:0] div_q;
	logic [`FRT_PRE_W-1:0] div_d;
	logic [`FRT_PRE_W-1:0] mask;
	assign div_d = run ? div_q + 3'h1 : div_q;
	assign mask = (sel == `FRT_CC_DIV2) ? 3'h1 : (sel == `FRT_CC_DIV4) ? 3'h3 : 3'h7;
	assign tick = run && ((div_q & mask) == mask);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			div_q <= 3'h0;
		end else begin
			div_q <= div_d;
		end
	end
endmodule
